// *** shared/ivr_params.svh ***
`ifndef IVR_PARAMS_SVH
`define IVR_PARAMS_SVH

// Register map, byte addresses on the bus
`define IVR_MCU_CONTROL_ADDR 8'h00
`define IVR_STATUS_ADDR 8'h04
`define IVR_CONFIG_ADDR 8'h08
`define IVR_RESET_ENTRY_ADDR 8'h0c
`define IVR_VECTOR_BASE_ADDR 8'h10

// Field positions in the control register
`define IVR_CHANGE_EN_BIT 0
`define IVR_SELECT_BIT 1

// Field positions in the configuration register
`define IVR_BOOT_RESET_FUSE_BIT 0
`define IVR_BOOT_SIZE_LSB 1
`define IVR_APP_LOCK_BIT 3
`define IVR_BOOT_LOCK_BIT 4
`define IVR_GLOBAL_IE_BIT 5

// Field positions in the status register
`define IVR_STAT_MASKED_BIT 0
`define IVR_STAT_BLOCKED_BIT 1
`define IVR_STAT_EXEC_BOOT_BIT 2

// Reset values
`define IVR_CONTROL_RESET 8'h00
`define IVR_CONFIG_RESET 8'h3f

// Unlock window in system clock cycles
`define IVR_UNLOCK_CYCLES 3'h4

// Flash geometry, word addresses
`define IVR_FLASH_TOP 14'h2000
`define IVR_BOOT_2K_WORDS 14'h0400
`define IVR_VECTOR_OFFSET 14'h0002
`define IVR_APP_VECTOR_BASE 14'h0001
`define IVR_RESET_APP 14'h0000

`endif

// *** shared/ivr_pkg.sv ***
`default_nettype none
package ivr_pkg;
  typedef enum logic [1:0] {
    IVR_IDLE,
    IVR_ARMED
  } ivr_unlock_state_t;

  typedef logic [13:0] ivr_word_addr_t;
endpackage
`default_nettype wire

// *** logic/ivr_boot_map.sv ***
`include "ivr_params.svh"
`default_nettype none
module ivr_boot_map
  import ivr_pkg::*;
(
  // Fuse inputs and vector table select
  input wire logic [1:0] boot_size_fuses_i,
  input wire logic boot_reset_fuse_i,
  input wire logic vector_table_select_i,
  // Address outputs
  output ivr_word_addr_t boot_start_o,
  output ivr_word_addr_t reset_entry_o,
  output ivr_word_addr_t vector_base_o
);
  ivr_word_addr_t boot_words;

  // Fuses 2'b00 give the largest section, 2'b11 the smallest
  always_comb begin
    boot_words = `IVR_BOOT_2K_WORDS >> boot_size_fuses_i;
  end

  assign boot_start_o = `IVR_FLASH_TOP - boot_words;
  // Fuse low means programmed
  assign reset_entry_o = boot_reset_fuse_i ? `IVR_RESET_APP
                                           : boot_start_o;
  assign vector_base_o = vector_table_select_i
      ? boot_start_o + `IVR_VECTOR_OFFSET
      : `IVR_APP_VECTOR_BASE;
endmodule
`default_nettype wire

// *** logic/ivr_unlock.sv ***
`include "ivr_params.svh"
`default_nettype none
module ivr_unlock
  import ivr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control register writes
  input wire logic wr_i,
  input wire logic change_en_i,
  input wire logic select_i,
  // State
  output logic change_en_o,
  output logic select_o,
  output logic mask_o
);
  ivr_unlock_state_t state;
  logic [2:0] count;
  logic hold_one;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= IVR_IDLE;
      count <= 3'h0;
      select_o <= 1'b0;
    end else begin
      case (state)
        IVR_IDLE: begin
          if (wr_i && change_en_i) begin
            state <= IVR_ARMED;
            count <= `IVR_UNLOCK_CYCLES - 3'h1;
          end
        end
        IVR_ARMED: begin
          if (wr_i && !change_en_i) begin
            select_o <= select_i;
            state <= IVR_IDLE;
          end else if (wr_i) begin
            // Rewriting the enable restarts its window
            count <= `IVR_UNLOCK_CYCLES - 3'h1;
          end else if (count == 3'h0) begin
            state <= IVR_IDLE;
          end else begin
            count <= count - 3'h1;
          end
        end
        default: state <= IVR_IDLE;
      endcase
    end
  end

  // Keeps masking for the instruction after the select write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_one <= 1'b0;
    end else begin
      hold_one <= state == IVR_ARMED && wr_i && !change_en_i;
    end
  end

  assign change_en_o = state == IVR_ARMED;
  // Combinational so masking starts in the enable write cycle
  assign mask_o = change_en_o || hold_one ||
                  (state == IVR_IDLE && wr_i && change_en_i);
endmodule
`default_nettype wire

// *** logic/ivr_top.sv ***
// Overview of operation
// - Select zero places vectors at the start of flash.
// - Select one places vectors at the boot section start.
// - Boot section start comes from the boot size fuses.
// - Select updates only if written, enable zero, within four cycles.
// - Interrupts masked from enable set until after the select write.
// - Without select write, masking lasts five cycles, the enable write cycle included.
// - Automatic masking leaves the global interrupt enable untouched.
// - Enable clears after four cycles or on select write.
// - Boot vectors plus application lock block interrupts in application.
// - Application vectors plus boot lock block interrupts in boot code.
// - 2K boot section: reset at 0x1c00, vectors from 0x1c02.
// - Boot reset fuse picks the reset entry; the boot size fuses set its boot address.
//
// Chosen here: the address map and the Wishbone register port.
`include "ivr_params.svh"
`default_nettype none
module ivr_top
  import ivr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Core interface
  input wire logic [13:0] pc_i,
  input wire logic irq_req_i,
  output logic irq_take_o,
  output ivr_word_addr_t vector_base_o,
  output ivr_word_addr_t reset_entry_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] config_reg;
  logic req;
  logic wr_ctrl;
  logic change_en;
  logic select;
  logic mask;
  logic exec_boot;
  logic blocked;
  ivr_word_addr_t boot_start;
  ivr_word_addr_t next_vector_base;
  ivr_word_addr_t next_reset_entry;
  logic [31:0] next_dat;
  logic next_err;

  // An error answer also blocks a second take of the same request
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_ctrl = req && we_i && sel_i[0] &&
                   adr_i == `IVR_MCU_CONTROL_ADDR;

  ////////////////////////////////////////////////////////////////////////////
  ivr_unlock u_unlock (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_ctrl),
    .change_en_i(dat_i[`IVR_CHANGE_EN_BIT]),
    .select_i(dat_i[`IVR_SELECT_BIT]),
    .change_en_o(change_en),
    .select_o(select),
    .mask_o(mask)
  );

  ivr_boot_map u_map (
    .boot_size_fuses_i(config_reg[`IVR_BOOT_SIZE_LSB +: 2]),
    .boot_reset_fuse_i(config_reg[`IVR_BOOT_RESET_FUSE_BIT]),
    .vector_table_select_i(select),
    .boot_start_o(boot_start),
    .reset_entry_o(next_reset_entry),
    .vector_base_o(next_vector_base)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lock bits are active low like the fuses: zero means programmed
  assign exec_boot = pc_i >= boot_start;
  assign blocked =
      (select && !config_reg[`IVR_APP_LOCK_BIT] && !exec_boot) ||
      (!select && !config_reg[`IVR_BOOT_LOCK_BIT] && exec_boot);

  // Global enable is only read here, never written by the mask path
  assign irq_take_o = irq_req_i && config_reg[`IVR_GLOBAL_IE_BIT] &&
                      !mask && !blocked;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vector_base_o <= `IVR_APP_VECTOR_BASE;
      reset_entry_o <= `IVR_RESET_APP;
    end else begin
      vector_base_o <= next_vector_base;
      reset_entry_o <= next_reset_entry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fuses and lock bits live in a software register; real silicon straps
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_reg <= `IVR_CONFIG_RESET;
    end else if (req && we_i && sel_i[0] &&
                 adr_i == `IVR_CONFIG_ADDR) begin
      config_reg <= dat_i[7:0];
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    next_err = 1'b0;
    if (adr_i == `IVR_MCU_CONTROL_ADDR) begin
      next_dat[`IVR_CHANGE_EN_BIT] = change_en;
      next_dat[`IVR_SELECT_BIT] = select;
    end else if (adr_i == `IVR_STATUS_ADDR) begin
      next_dat[`IVR_STAT_MASKED_BIT] = mask;
      next_dat[`IVR_STAT_BLOCKED_BIT] = blocked;
      next_dat[`IVR_STAT_EXEC_BOOT_BIT] = exec_boot;
    end else if (adr_i == `IVR_CONFIG_ADDR) begin
      next_dat[7:0] = config_reg;
    end else if (adr_i == `IVR_RESET_ENTRY_ADDR) begin
      next_dat[13:0] = reset_entry_o;
    end else if (adr_i == `IVR_VECTOR_BASE_ADDR) begin
      next_dat[13:0] = vector_base_o;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req && !next_err;
      err_o <= req && next_err;
      dat_o <= req ? next_dat : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// *** verification/ivr_monitor.sv ***
`default_nettype none
module ivr_monitor
  import ivr_pkg::*;
(
  // Bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic err_o,
  // Core
  input wire logic irq_req_i,
  input wire logic irq_take_o,
  input wire logic [13:0] vector_base_o,
  input wire logic [13:0] reset_entry_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic tk;
  logic en_wr;
  assign tk = cyc_i & stb_i & !ack_o & !err_o;
  assign en_wr = tk && we_i && sel_i[0] && adr_i == 8'h00 && dat_i[0];
  ack_one_a: assert property (tk |=> ack_o ^ err_o)
    else $error("no answer");
  ack_drop_a: assert property (ack_o |=> !ack_o)
    else $error("ack held");
  take_cause_a: assert property (irq_take_o |-> irq_req_i)
    else $error("take without request");
  mask_hold_a: assert property (en_wr |-> (!irq_take_o) [*4])
    else $error("unlock not masked");
  base_set_a: assert property (vector_base_o inside {14'h0001,
    14'h1c02, 14'h1e02, 14'h1f02, 14'h1f82}) else $error("bad base");
  entry_set_a: assert property (reset_entry_o inside {14'h0000,
    14'h1c00, 14'h1e00, 14'h1f00, 14'h1f80}) else $error("bad entry");
  err_map_a: assert property (tk && !(adr_i inside {8'h00,
    8'h04, 8'h08, 8'h0c, 8'h10}) |=> err_o) else $error("no error");
  base_move_a: assert property ($changed(vector_base_o) |->
    ack_o || $past(ack_o) || $past(ack_o, 2)) else $error("base moved");
endmodule
bind ivr_top ivr_monitor mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .sel_i, .dat_i, .ack_o, .err_o, .irq_req_i, .irq_take_o,
  .vector_base_o, .reset_entry_o);
`default_nettype wire

// *** verification/ivr_top_bench.sv ***
`default_nettype none
module ivr_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, erf;
  logic irq_req_i = 0, ack_o, err_o, irq_take_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h1;
  logic [31:0] dat_i = 32'h0, dat_o, rd_v;
  logic [13:0] pc_i = 14'h0, vector_base_o, reset_entry_o;
  int err_count = 0, n_checks = 0;
  always #2 clk_i = ~clk_i;
  ivr_top uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .pc_i, .irq_req_i, .irq_take_o,
    .vector_base_o, .reset_entry_o);
  task finish_test;
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Values are sampled at the edge, before that edge's updates land
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    for (i = 0; i < 9; i++) begin
      @(posedge clk_i);
      if (ack_o | err_o) break;
    end
    rd_v = dat_o;
    erf = err_o;
    cyc_i <= 0;
    stb_i <= 0;
    if (i == 9) begin
      chk(0, 1);
      finish_test;
    end
    @(posedge clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    int s;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk(vector_base_o, 1);
    chk(reset_entry_o, 0);
    bus(8'h00, 1, 2);
    bus(8'h00, 0, 0);
    chk(rd_v, 0);
    bus(8'h08, 1, 32'h38);
    chk(reset_entry_o, 14'h1c00);
    chk(vector_base_o, 1);
    bus(8'h0c, 0, 0);
    chk(rd_v, 32'h1c00);
    irq_req_i <= 1;
    @(posedge clk_i);
    chk(irq_take_o, 1);
    bus(8'h00, 1, 1);
    chk(irq_take_o, 0);
    bus(8'h00, 1, 2);
    chk(vector_base_o, 14'h1c02);
    bus(8'h10, 0, 0);
    chk(rd_v, 32'h1c02);
    bus(8'h00, 0, 0);
    chk(rd_v, 2);
    bus(8'h08, 0, 0);
    chk(rd_v, 32'h38);
    bus(8'h00, 1, 1);
    chk(irq_take_o, 0);
    bus(8'h00, 0, 0);
    chk(rd_v, 3);
    bus(8'h00, 0, 0);
    chk(rd_v, 2);
    chk(irq_take_o, 1);
    bus(8'h00, 1, 0);
    chk(vector_base_o, 14'h1c02);
    for (s = 0; s < 4; s++) begin
      bus(8'h08, 1, 32'h38 | (s << 1));
      chk(vector_base_o, 14'h2002 - (14'h400 >> s));
    end
    bus(8'h08, 1, 32'h30);
    repeat (2) @(posedge clk_i);
    chk(irq_take_o, 0);
    bus(8'h04, 0, 0);
    chk(rd_v, 2);
    pc_i <= 14'h1c10;
    repeat (2) @(posedge clk_i);
    chk(irq_take_o, 1);
    bus(8'h00, 1, 1);
    bus(8'h00, 1, 0);
    chk(vector_base_o, 1);
    bus(8'h08, 1, 32'h28);
    repeat (2) @(posedge clk_i);
    chk(irq_take_o, 0);
    bus(8'h04, 0, 0);
    chk(rd_v, 6);
    pc_i <= 14'h0;
    repeat (2) @(posedge clk_i);
    chk(irq_take_o, 1);
    bus(8'h14, 0, 0);
    chk(erf, 1);
    finish_test;
  end
endmodule
`default_nettype wire
